// ===== opctl_pkg.sv
// package: register map, field positions and shared types of the io/operation control bank
package opctl_pkg;

    // register indices; the APB byte address is four times the index
    localparam int IOCFG2_INDEX = 1;
    localparam int OPCTL_INDEX = 2;
    localparam logic [7:0] OPCTL_ADDR = 8'(4 * OPCTL_INDEX);
    localparam logic [7:0] IOCFG2_ADDR = 8'(4 * IOCFG2_INDEX);

    // io configuration second fields
    localparam int IOCFG_LOW_SUPPLY_BIT = 7;
    localparam int IOCFG_REG_OFF_BIT = 6;
    localparam int IOCFG_PD_SEL_IDLE_BIT = 4;
    localparam int IOCFG_PD_DESEL_BIT = 3;
    localparam int IOCFG_DRIVE_BIT = 2;
    localparam int IOCFG_SLOW_RAMP_BIT = 0;
    localparam logic [7:0] IOCFG_WRITE_MASK = 8'hDD;

    // operation control fields
    localparam int OPCTL_READY_BIT = 7;
    localparam int OPCTL_RX_EN_BIT = 6;
    localparam int OPCTL_ONE_CHAN_BIT = 5;
    localparam int OPCTL_MANUAL_BIT = 4;
    localparam int OPCTL_TX_EN_BIT = 3;
    localparam int OPCTL_WAKE_BIT = 2;
    localparam logic [7:0] OPCTL_WRITE_MASK = 8'hFC;

    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [1:0] {
        CHAN_BOTH_AUTO,
        CHAN_BOTH_MANUAL,
        CHAN_SINGLE
    } chan_mode_t;

    typedef struct packed {
        logic lowSupplyRangeSelect;
        logic digitalSupplyRailOff;
        logic dataoutPulldownSelectedIdle;
        logic dataoutPulldownDeselected;
        logic dataoutStrongDrive;
        logic txSlowRamp;
    } io_ctrl_t;

    typedef struct packed {
        logic readyMode;
        logic rxEnable;
        chan_mode_t chanMode;
        logic txEnable;
        logic wakeUpModeOn;
    } op_ctrl_t;

endpackage

// ===== miso_pad_ctrl.sv
// module: pull-down control for the serial data-out pad
`timescale 1ns/1ps
`default_nettype none
module miso_pad_ctrl (
    // configuration
    input wire logic pdSelIdleEn,
    input wire logic pdDeselEn,
    // pad state
    input wire logic selectN,
    input wire logic dataoutDriving,
    // pull-down request
    output logic pullDownOn
);
    always_comb begin
        pullDownOn = (pdSelIdleEn && !selectN && !dataoutDriving) // RULE3
            || (pdDeselEn && selectN); // RULE4
    end
endmodule
`default_nettype wire

// ===== opctl_regs.sv
// module: io configuration and operation control registers with an APB slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: io config bit 7 picks the 3.3 V supply range when set, 5 V when clear.
// RULE2: io config bit 6 set turns the digital supply rail regulator off.
// RULE3: io config bit 4 pulls the data-out pin down while selected and not driven.
// RULE4: io config bit 3 pulls the data-out pin down while deselected.
// RULE5: io config bit 2 raises data-out drive strength for a 1.8 V pad supply.
// RULE6: io config bit 0 selects the slow transmitter turn-on ramp.
// RULE7: all fields reset to zero on power-up reset only, nothing else reloads them.
// RULE8: operation control bit 7 enables oscillator and regulator (ready mode).
// RULE9: operation control bit 6 enables the receiver.
// RULE10: bit 5 clear enables both receive channels, set enables one picked by channel pick.
// RULE11: with both channels on, bit 4 chooses automatic (0) or manual pick (1).
// RULE12: bit 3 enables transmit, is set by field-on and cleared at end of active transmit.
// RULE13: bit 2 enables wake-up mode, timed by the wake-up timer settings.
// RULE14: unused bits ignore writes and read as zero.
module opctl_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // hardware events on the transmit enable
    input wire logic fieldOnCmd,
    input wire logic activeTxDone,
    // receiver channel pick from elsewhere
    input wire logic receiveChannelPick,
    // serial pad state
    input wire logic selectN,
    input wire logic dataoutDriving,
    // controls
    output opctl_pkg::io_ctrl_t ioCtrl,
    output opctl_pkg::op_ctrl_t opCtrl,
    output logic amChannelOn,
    output logic pmChannelOn,
    output logic autoChannelSelect,
    output logic dataoutPullDown
);
    logic [7:0] ioCfg_reg;
    logic [7:0] opCtl_reg;
    logic txEn_reg;
    logic [7:0] opView;
    logic wrAccess;
    logic hitIo;
    logic hitOp;

    assign hitIo = (paddr == opctl_pkg::IOCFG2_ADDR);
    assign hitOp = (paddr == opctl_pkg::OPCTL_ADDR);
    assign wrAccess = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hitIo || hitOp);
    assign opView = opCtl_reg | (8'(txEn_reg) << opctl_pkg::OPCTL_TX_EN_BIT);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ioCfg_reg <= opctl_pkg::REG_RESET; // RULE7
        end else if (wrAccess && hitIo) begin
            ioCfg_reg <= pwdata[7:0] & opctl_pkg::IOCFG_WRITE_MASK; // RULE14
        end
    end

    // software bits of operation control; transmit enable lives in its own flop
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            opCtl_reg <= opctl_pkg::REG_RESET; // RULE7
        end else if (wrAccess && hitOp) begin
            opCtl_reg <= pwdata[7:0] & opctl_pkg::OPCTL_WRITE_MASK & 8'hF7; // RULE14
        end
    end

    // hardware set beats the completion clear and any software write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            txEn_reg <= 1'b0; // RULE7
        end else if (fieldOnCmd) begin
            txEn_reg <= 1'b1; // RULE12
        end else if (wrAccess && hitOp) begin
            txEn_reg <= pwdata[opctl_pkg::OPCTL_TX_EN_BIT]; // RULE12
        end else if (activeTxDone) begin
            txEn_reg <= 1'b0; // RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data captured in the setup cycle, stands through the access cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (hitIo) begin
                prdata <= {24'h00_0000, ioCfg_reg};
            end else if (hitOp) begin
                prdata <= {24'h00_0000, opView};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        ioCtrl.lowSupplyRangeSelect = ioCfg_reg[opctl_pkg::IOCFG_LOW_SUPPLY_BIT]; // RULE1
        ioCtrl.digitalSupplyRailOff = ioCfg_reg[opctl_pkg::IOCFG_REG_OFF_BIT]; // RULE2
        ioCtrl.dataoutPulldownSelectedIdle = ioCfg_reg[opctl_pkg::IOCFG_PD_SEL_IDLE_BIT];
        ioCtrl.dataoutPulldownDeselected = ioCfg_reg[opctl_pkg::IOCFG_PD_DESEL_BIT];
        ioCtrl.dataoutStrongDrive = ioCfg_reg[opctl_pkg::IOCFG_DRIVE_BIT]; // RULE5
        ioCtrl.txSlowRamp = ioCfg_reg[opctl_pkg::IOCFG_SLOW_RAMP_BIT]; // RULE6
    end

    always_comb begin
        opCtrl.readyMode = opView[opctl_pkg::OPCTL_READY_BIT]; // RULE8
        opCtrl.rxEnable = opView[opctl_pkg::OPCTL_RX_EN_BIT]; // RULE9
        opCtrl.txEnable = opView[opctl_pkg::OPCTL_TX_EN_BIT]; // RULE12
        opCtrl.wakeUpModeOn = opView[opctl_pkg::OPCTL_WAKE_BIT]; // RULE13
        if (opView[opctl_pkg::OPCTL_ONE_CHAN_BIT]) begin
            opCtrl.chanMode = opctl_pkg::CHAN_SINGLE; // RULE10
        end else if (opView[opctl_pkg::OPCTL_MANUAL_BIT]) begin
            opCtrl.chanMode = opctl_pkg::CHAN_BOTH_MANUAL; // RULE11
        end else begin
            opCtrl.chanMode = opctl_pkg::CHAN_BOTH_AUTO; // RULE11
        end
    end

    // channel pick: 0 selects AM, 1 selects PM
    always_comb begin
        case (opCtrl.chanMode)
            opctl_pkg::CHAN_SINGLE: begin
                amChannelOn = opCtrl.rxEnable && !receiveChannelPick; // RULE10
                pmChannelOn = opCtrl.rxEnable && receiveChannelPick;
                autoChannelSelect = 1'b0;
            end
            opctl_pkg::CHAN_BOTH_MANUAL: begin
                amChannelOn = opCtrl.rxEnable;
                pmChannelOn = opCtrl.rxEnable;
                autoChannelSelect = 1'b0; // RULE11
            end
            default: begin
                amChannelOn = opCtrl.rxEnable;
                pmChannelOn = opCtrl.rxEnable;
                autoChannelSelect = opCtrl.rxEnable; // RULE11
            end
        endcase
    end

    miso_pad_ctrl padCtrl (
        .pdSelIdleEn(ioCtrl.dataoutPulldownSelectedIdle),
        .pdDeselEn(ioCtrl.dataoutPulldownDeselected),
        .selectN(selectN),
        .dataoutDriving(dataoutDriving),
        .pullDownOn(dataoutPullDown)
    );
endmodule
`default_nettype wire

// ===== opctl_regs_asserts.sv
// checker: port assertions for the io and operation control bank
`timescale 1ns/1ps
`default_nettype none
module opctl_regs_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // hardware events and pad state
    input wire logic fieldOnCmd,
    input wire logic activeTxDone,
    input wire logic receiveChannelPick,
    input wire logic selectN,
    input wire logic dataoutDriving,
    // controls
    input wire opctl_pkg::io_ctrl_t ioCtrl,
    input wire opctl_pkg::op_ctrl_t opCtrl,
    input wire logic amChannelOn,
    input wire logic pmChannelOn,
    input wire logic autoChannelSelect,
    input wire logic dataoutPullDown
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr; psel && penable && pwrite; endsequence
    sequence s_wrIo; s_wr ##0 paddr == opctl_pkg::IOCFG2_ADDR; endsequence
    sequence s_wrOp; s_wr ##0 paddr == opctl_pkg::OPCTL_ADDR; endsequence
    property p_ioWr;
        s_wrIo |=> ioCtrl == {$past(pwdata[7:6]), $past(pwdata[4:2]), $past(pwdata[0])};
    endproperty
    a_ioWr: assert property (p_ioWr) else $error("io write not stored");
    property p_pull; dataoutPullDown == (ioCtrl.dataoutPulldownSelectedIdle && !selectN
        && !dataoutDriving || ioCtrl.dataoutPulldownDeselected && selectN); endproperty
    a_pull: assert property (p_pull) else $error("pull-down wrong");
    property p_rst; disable iff (1'b0) sys_rst |=> ioCtrl == '0 && opCtrl == '0; endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    property p_hold; !(psel && penable && pwrite) |=> $stable(ioCtrl); endproperty
    a_hold: assert property (p_hold) else $error("io config changed alone");
    property p_tx; fieldOnCmd |=> opCtrl.txEnable; endproperty
    a_tx: assert property (p_tx) else $error("field-on did not set tx");
    property p_opWr;
        s_wrOp |=> opCtrl.readyMode == $past(pwdata[7]) && opCtrl.rxEnable == $past(pwdata[6])
            && opCtrl.wakeUpModeOn == $past(pwdata[2]);
    endproperty
    a_opWr: assert property (p_opWr) else $error("op write not stored");
    property p_txClr;
        activeTxDone && !fieldOnCmd && !(psel && penable && pwrite
            && paddr == opctl_pkg::OPCTL_ADDR) |=> !opCtrl.txEnable;
    endproperty
    a_txClr: assert property (p_txClr) else $error("tx done did not clear tx");
    property p_rxOff; !opCtrl.rxEnable |-> !amChannelOn && !pmChannelOn; endproperty
    a_rxOff: assert property (p_rxOff) else $error("channel on with rx off");
    property p_one; opCtrl.rxEnable && opCtrl.chanMode == opctl_pkg::CHAN_SINGLE
        |-> pmChannelOn == receiveChannelPick && amChannelOn == !receiveChannelPick; endproperty
    a_one: assert property (p_one) else $error("single channel wrong");
    property p_auto; opCtrl.rxEnable && opCtrl.chanMode == opctl_pkg::CHAN_BOTH_AUTO
        |-> autoChannelSelect && amChannelOn && pmChannelOn; endproperty
    a_auto: assert property (p_auto) else $error("auto selection wrong");
    property p_rdOp; psel && penable && !pwrite && paddr == opctl_pkg::OPCTL_ADDR
        |-> prdata[31:8] == 24'h000000 && prdata[1:0] == 2'h0; endproperty
    a_rdOp: assert property (p_rdOp) else $error("unused bits read nonzero");
endmodule
bind opctl_regs opctl_regs_asserts u_asserts (.*);
`default_nettype wire

// ===== tb_top.sv
// testbench: apb access, channel, pull-down and transmit enable checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic fieldOnCmd = 0, activeTxDone = 0, receiveChannelPick = 0, selectN = 1;
    logic dataoutDriving = 0, amChannelOn, pmChannelOn, autoChannelSelect, dataoutPullDown;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    opctl_pkg::io_ctrl_t ioCtrl;
    opctl_pkg::op_ctrl_t opCtrl;
    int n_fail = 0, checks_done = 0;
    localparam logic [7:0] IO = opctl_pkg::IOCFG2_ADDR, OP = opctl_pkg::OPCTL_ADDR;
    always #12.5 core_clk = ~core_clk;
    opctl_regs u_dut (.*);
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge core_clk);
        penable <= 1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        #1;
    endtask
    task automatic t_regs();
        for (int b = 0; b < 8; b++) begin
            logic [7:0] d;
            logic [5:0] e;
            d = 8'h01 << b;
            e = {d[7:6], d[5] ? 2'h2 : {1'b0, d[4]}, d[3:2]};
            apb(1, IO, 32'(d));
            apb(0, IO, 32'h00000000);
            chk("io read", rd, 32'(d & 8'hDD));
            chk("ioCtrl", 32'(ioCtrl), 32'({d[7:6], d[4:2], d[0]}));
            apb(1, OP, 32'(d | 8'h03));
            apb(0, OP, 32'h00000000);
            chk("op read", rd, 32'(d & 8'hFC));
            chk("opCtrl", 32'(opCtrl), 32'(e));
        end
        $display("register test done");
    endtask
    task automatic t_chan();
        for (int p = 0; p < 2; p++) begin
            @(posedge core_clk) receiveChannelPick <= p[0];
            apb(1, OP, 32'h00000060);
            chk("single", 32'({amChannelOn, pmChannelOn}), 32'({!p[0], p[0]}));
            apb(1, OP, 32'h00000040);
            chk("auto", 32'({amChannelOn, pmChannelOn, autoChannelSelect}), 32'h7);
            apb(1, OP, 32'h00000050);
            chk("manual", 32'(autoChannelSelect), 32'h0);
            apb(1, OP, 32'h00000000);
            chk("rx off", 32'({amChannelOn, pmChannelOn}), 32'h0);
        end
        $display("channel test done");
    endtask
    task automatic t_pull();
        for (int c = 3; c < 5; c++) begin
            apb(1, IO, 32'h1 << c);
            for (int k = 0; k < 4; k++) begin
                @(posedge core_clk) {selectN, dataoutDriving} <= k[1:0];
                #1;
                chk("pull", 32'(dataoutPullDown), 32'(c == 4 ? k == 0 : k > 1));
            end
        end
        $display("pull-down test done");
    endtask
    task automatic t_tx();
        apb(1, OP, 32'h00000008);
        chk("tx write", 32'(opCtrl.txEnable), 32'h1);
        for (int k = 1; k < 4; k++) begin
            @(posedge core_clk) {fieldOnCmd, activeTxDone} <= k[1:0];
            @(posedge core_clk) {fieldOnCmd, activeTxDone} <= 2'h0;
            #1;
            chk("tx event", 32'(opCtrl.txEnable), 32'(k != 1));
        end
        @(posedge core_clk) fieldOnCmd <= 1'b1;
        apb(1, OP, 32'h00000000);
        chk("set beats write", 32'(opCtrl.txEnable), 32'h1);
        @(posedge core_clk) {fieldOnCmd, activeTxDone} <= 2'h1;
        apb(1, OP, 32'h00000008);
        chk("write beats clear", 32'(opCtrl.txEnable), 32'h1);
        @(posedge core_clk) activeTxDone <= 1'b0;
        apb(1, 8'h0C, 32'h000000FF);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped write", 32'(ioCtrl), 32'h08);
        apb(0, 8'h0C, 32'h00000000);
        chk("unmapped read", rd, 32'h0);
        @(posedge core_clk) sys_rst <= 1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 0;
        apb(0, OP, 32'h00000000);
        chk("op after reset", rd, 32'h0);
        chk("io after reset", 32'(ioCtrl), 32'h0);
        $display("transmit and reset test done");
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 0;
        t_regs();
        t_chan();
        t_pull();
        t_tx();
        end_of_test();
    end
endmodule
`default_nettype wire
